// File: include/irq_agg_pkg.sv
// Register map, field positions and reset values of the event aggregator
package irq_agg_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          NUM_SRC         = 16;
  localparam logic [11:0] ENABLE_OFFSET   = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;
  localparam logic [15:0] ENABLE_RESET    = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  // Bit positions, shared by status and enable
  localparam int SYS_ERR_BIT         = 0;
  localparam int PARITY_ERR_BIT      = 1;
  localparam int RX_CHECK_ERR_BIT    = 2;
  localparam int RX_ABORT_BIT        = 3;
  localparam int RX_FORMAT_ERR_BIT   = 4;
  localparam int RX_OVERRUN_BIT      = 5;
  localparam int RX_SMALL_FREE_BIT   = 6;
  localparam int RX_LARGE_FREE_BIT   = 7;
  localparam int RX_READY_WRITE_BIT  = 8;
  localparam int RX_FREE_EMPTY_BIT   = 9;
  localparam int RX_READY_FULL_BIT   = 10;
  localparam int TX_FREE_WRITE_BIT   = 11;
  localparam int TX_READY_READ_BIT   = 12;
  localparam int TX_FREE_FULL_BIT    = 13;
  localparam int TX_DONE_BIT         = 14;
  localparam int TX_UNDERFLOW_BIT    = 15;
  // Packet length limits for the format check, and the ones run of an abort
  localparam int MIN_BITS_CRC16      = 32;
  localparam int MIN_BITS_CRC32      = 48;
  localparam int ABORT_ONES          = 7;
endpackage

// File: src/master_interrupt_aggregator.sv
// Event status latch, enable mask and host interrupt output
// Functional notes
// - Flag packets too long, short or unaligned
// - Enable gates interrupt; status still sets
// - Overrun on write to full FIFO
// - Event after small free queue fetch batch
// - Event after large free queue fetch batch
// - Event after ready queue write batch
// - Error on free request when both free queues empty
// - Error writing to full ready queue
// - Event after transmit free queue write batch
// - Event after transmit ready queue fetch batch
// - Error writing full transmit free queue
// - Done event for flagged finished packets
// - Underflow on read of empty FIFO
// - Status bit order matches mask, upper zero
// - Status read returns then clears all
// - Byte lanes ignored; no lanes, no access
// - System error from address/special/abort faults
// - Parity error as master or reported
// - Check sequence mismatch sets status
// - Seven ones abort sets status
module master_interrupt_aggregator #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // Register port, same clock
  input  wire logic                 reg_sel,
  input  wire logic                 reg_write,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [3:0]           cmd_byte_sel_n,
  input  wire logic [31:0]          reg_wdata,
  output logic      [31:0]          reg_rdata,
  // Receive frame end report
  input  wire logic                 rx_frame_end,
  input  wire logic [LEN_W-1:0]     rx_frame_bits,
  input  wire logic [LEN_W-1:0]     rx_max_bits,
  input  wire logic                 rx_crc32_mode,
  input  wire logic                 rx_crc_mismatch,
  input  wire logic                 rx_ones_run_hit,
  // Queue and FIFO event strobes
  input  wire logic                 rx_fifo_write,
  input  wire logic                 rx_fifo_full,
  input  wire logic                 rx_small_batch_done,
  input  wire logic                 rx_large_batch_done,
  input  wire logic                 rx_ready_batch_done,
  input  wire logic                 rx_free_request,
  input  wire logic                 rx_small_empty,
  input  wire logic                 rx_large_empty,
  input  wire logic                 rx_ready_write,
  input  wire logic                 rx_ready_full,
  input  wire logic                 tx_free_batch_done,
  input  wire logic                 tx_ready_batch_done,
  input  wire logic                 tx_free_write,
  input  wire logic                 tx_free_full,
  input  wire logic                 tx_packet_done,
  input  wire logic                 notify_on_done,
  input  wire logic                 tx_fifo_read,
  input  wire logic                 tx_fifo_empty,
  // Bus error reports
  input  wire logic                 addr_parity_err,
  input  wire logic                 special_data_parity_err,
  input  wire logic                 master_abort_seen,
  input  wire logic                 target_abort_seen,
  input  wire logic                 master_data_parity_err,
  input  wire logic                 parity_fault_in_n,
  // Host interrupt
  output logic                      host_irq_n
);

  typedef struct packed {
    logic [1:0]  perr_sync;
    logic [15:0] enable;
    logic [15:0] status;
    logic [31:0] rdata;
    logic        irq_n;
  } state_t;

  state_t st;
  state_t next_st;
  logic   rst_n_int;
  logic   rst_stage;
  logic   rst_done;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_stage <= 1'b0;
      rst_done  <= 1'b0;
    end else begin
      rst_stage <= 1'b1;
      rst_done  <= rst_stage;
    end
  end
  assign rst_n_int = rst_done;

  logic        access;
  logic        rd_status;
  logic        wr_enable;
  logic        too_long;
  logic        too_short;
  logic        unaligned;
  logic [15:0] events;

  always_comb begin
    // No lane asserted means no access at all
    access    = reg_sel && (cmd_byte_sel_n != 4'hf);
    rd_status = access && !reg_write && (reg_addr == irq_agg_pkg::STATUS_OFFSET);
    wr_enable = access && reg_write && (reg_addr == irq_agg_pkg::ENABLE_OFFSET);

    too_long  = rx_frame_bits > rx_max_bits;
    too_short = rx_crc32_mode ? (rx_frame_bits < LEN_W'(irq_agg_pkg::MIN_BITS_CRC32))
                              : (rx_frame_bits < LEN_W'(irq_agg_pkg::MIN_BITS_CRC16));
    unaligned = rx_frame_bits[2:0] != 3'h0;

    events = 16'h0000;
    events[irq_agg_pkg::SYS_ERR_BIT] = addr_parity_err || special_data_parity_err
                                     || master_abort_seen || target_abort_seen;
    // Sync output of the external parity pin, second stage only
    events[irq_agg_pkg::PARITY_ERR_BIT] = master_data_parity_err || !st.perr_sync[1];
    events[irq_agg_pkg::RX_CHECK_ERR_BIT]  = rx_frame_end && rx_crc_mismatch;
    events[irq_agg_pkg::RX_ABORT_BIT]      = rx_ones_run_hit;
    events[irq_agg_pkg::RX_FORMAT_ERR_BIT] = rx_frame_end && (too_long || too_short || unaligned);
    events[irq_agg_pkg::RX_OVERRUN_BIT]     = rx_fifo_write && rx_fifo_full;
    events[irq_agg_pkg::RX_SMALL_FREE_BIT]  = rx_small_batch_done;
    events[irq_agg_pkg::RX_LARGE_FREE_BIT]  = rx_large_batch_done;
    events[irq_agg_pkg::RX_READY_WRITE_BIT] = rx_ready_batch_done;
    events[irq_agg_pkg::RX_FREE_EMPTY_BIT]  = rx_free_request && rx_small_empty
                                            && rx_large_empty;
    events[irq_agg_pkg::RX_READY_FULL_BIT]  = rx_ready_write && rx_ready_full;
    events[irq_agg_pkg::TX_FREE_WRITE_BIT]  = tx_free_batch_done;
    events[irq_agg_pkg::TX_READY_READ_BIT]  = tx_ready_batch_done;
    events[irq_agg_pkg::TX_FREE_FULL_BIT]   = tx_free_write && tx_free_full;
    events[irq_agg_pkg::TX_DONE_BIT]        = tx_packet_done && notify_on_done;
    events[irq_agg_pkg::TX_UNDERFLOW_BIT]   = tx_fifo_read && tx_fifo_empty;

    next_st = st;
    next_st.perr_sync = {st.perr_sync[0], parity_fault_in_n};
    if (wr_enable) begin
      next_st.enable = reg_wdata[15:0];
    end
    // Read data captured from the pre-clear status; new events survive the clear
    next_st.rdata = 32'h0000_0000;
    if (access && !reg_write) begin
      if (reg_addr == irq_agg_pkg::STATUS_OFFSET) begin
        next_st.rdata = {16'h0000, st.status};
      end else if (reg_addr == irq_agg_pkg::ENABLE_OFFSET) begin
        next_st.rdata = {16'h0000, st.enable};
      end
    end
    next_st.status = (rd_status ? 16'h0000 : st.status) | events;
    next_st.irq_n  = ~|(next_st.status & next_st.enable);
  end

  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st.perr_sync <= 2'h3;
      st.enable    <= irq_agg_pkg::ENABLE_RESET;
      st.status    <= irq_agg_pkg::STATUS_RESET;
      st.rdata     <= 32'h0000_0000;
      st.irq_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata  = st.rdata;
  assign host_irq_n = st.irq_n;

  chk_irq_releases: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rd_status && events == 16'h0000) |=> host_irq_n)
    else $error("interrupt stayed low after clearing read");

  chk_read_clears_all: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    rd_status |=> (st.status == $past(events)) && (reg_rdata[15:0] == $past(st.status)))
    else $error("status read did not return and clear");

  chk_no_lane_noop: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (reg_sel && cmd_byte_sel_n == 4'hf) |=> st.status == ($past(st.status) | $past(events)))
    else $error("access without byte lanes changed status");

  chk_masked_still_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (events[irq_agg_pkg::TX_UNDERFLOW_BIT] && !st.enable[irq_agg_pkg::TX_UNDERFLOW_BIT]
     && !wr_enable) |=> st.status[irq_agg_pkg::TX_UNDERFLOW_BIT])
    else $error("masked event not latched");

  chk_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    reg_rdata[31:16] == 16'h0000)
    else $error("upper status bits not zero");

  chk_overrun_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_fifo_write && rx_fifo_full) |=> st.status[irq_agg_pkg::RX_OVERRUN_BIT])
    else $error("overrun not latched");

  chk_short_frame: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && !rx_crc32_mode && rx_frame_bits == LEN_W'(24))
    |=> st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    else $error("short frame not flagged");

  chk_done_needs_flag: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (tx_packet_done && !notify_on_done && !$past(st.status[irq_agg_pkg::TX_DONE_BIT], 1)
     && !st.status[irq_agg_pkg::TX_DONE_BIT]) |=> !st.status[irq_agg_pkg::TX_DONE_BIT])
    else $error("done flag set without notify");

  chk_enable_write: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    wr_enable |=> st.enable == $past(reg_wdata[15:0]))
    else $error("enable write lost");

  chk_irq_asserts: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    ((events & st.enable) != 16'h0000 && !wr_enable) |=> !host_irq_n)
    else $error("enabled event did not raise interrupt");

  chk_sys_err_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (addr_parity_err || special_data_parity_err || master_abort_seen || target_abort_seen)
    |=> st.status[irq_agg_pkg::SYS_ERR_BIT])
    else $error("system error not latched");

  chk_master_parity_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    master_data_parity_err |=> st.status[irq_agg_pkg::PARITY_ERR_BIT])
    else $error("master parity error not latched");

  // Pin goes through both sync stages before it can set the bit
  chk_parity_pin_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    !parity_fault_in_n |-> ##3 st.status[irq_agg_pkg::PARITY_ERR_BIT])
    else $error("reported parity fault not latched");

  chk_check_err_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && rx_crc_mismatch) |=> st.status[irq_agg_pkg::RX_CHECK_ERR_BIT])
    else $error("check sequence error not latched");

  chk_abort_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    rx_ones_run_hit |=> st.status[irq_agg_pkg::RX_ABORT_BIT])
    else $error("abort not latched");

  chk_long_frame: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && rx_frame_bits > rx_max_bits)
    |=> st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    else $error("long frame not flagged");

  chk_unaligned_frame: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && rx_frame_bits[2:0] != 3'h0)
    |=> st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    else $error("unaligned frame not flagged");

  chk_crc32_short: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && rx_crc32_mode && rx_frame_bits < LEN_W'(irq_agg_pkg::MIN_BITS_CRC32))
    |=> st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    else $error("short long-check frame not flagged");

  chk_good_frame_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_frame_end && rx_frame_bits <= rx_max_bits && rx_frame_bits[2:0] == 3'h0
     && rx_frame_bits >= LEN_W'(irq_agg_pkg::MIN_BITS_CRC32)
     && !st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    |=> !st.status[irq_agg_pkg::RX_FORMAT_ERR_BIT])
    else $error("well formed frame flagged");

  chk_overrun_needs_full: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_fifo_write && !rx_fifo_full && !st.status[irq_agg_pkg::RX_OVERRUN_BIT])
    |=> !st.status[irq_agg_pkg::RX_OVERRUN_BIT])
    else $error("overrun without full fifo");

  chk_small_batch_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    rx_small_batch_done |=> st.status[irq_agg_pkg::RX_SMALL_FREE_BIT])
    else $error("small free batch not latched");

  chk_large_batch_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    rx_large_batch_done |=> st.status[irq_agg_pkg::RX_LARGE_FREE_BIT])
    else $error("large free batch not latched");

  chk_ready_batch_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    rx_ready_batch_done |=> st.status[irq_agg_pkg::RX_READY_WRITE_BIT])
    else $error("ready queue batch not latched");

  chk_free_empty_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_free_request && rx_small_empty && rx_large_empty)
    |=> st.status[irq_agg_pkg::RX_FREE_EMPTY_BIT])
    else $error("empty free queues not latched");

  chk_free_needs_both: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_free_request && !rx_small_empty && !st.status[irq_agg_pkg::RX_FREE_EMPTY_BIT])
    |=> !st.status[irq_agg_pkg::RX_FREE_EMPTY_BIT])
    else $error("free queue error with a queue left");

  chk_ready_full_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (rx_ready_write && rx_ready_full) |=> st.status[irq_agg_pkg::RX_READY_FULL_BIT])
    else $error("ready queue full error not latched");

  chk_tx_free_batch: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    tx_free_batch_done |=> st.status[irq_agg_pkg::TX_FREE_WRITE_BIT])
    else $error("transmit free batch not latched");

  chk_tx_ready_batch: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    tx_ready_batch_done |=> st.status[irq_agg_pkg::TX_READY_READ_BIT])
    else $error("transmit ready batch not latched");

  chk_tx_free_full: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (tx_free_write && tx_free_full) |=> st.status[irq_agg_pkg::TX_FREE_FULL_BIT])
    else $error("transmit free full error not latched");

  chk_done_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (tx_packet_done && notify_on_done) |=> st.status[irq_agg_pkg::TX_DONE_BIT])
    else $error("flagged done not latched");

  chk_underflow_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (tx_fifo_read && tx_fifo_empty) |=> st.status[irq_agg_pkg::TX_UNDERFLOW_BIT])
    else $error("underflow not latched");

  chk_read_needs_empty: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (tx_fifo_read && !tx_fifo_empty && !st.status[irq_agg_pkg::TX_UNDERFLOW_BIT])
    |=> !st.status[irq_agg_pkg::TX_UNDERFLOW_BIT])
    else $error("underflow without empty fifo");

  chk_no_lane_mask: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (reg_sel && cmd_byte_sel_n == 4'hf) |=> st.enable == $past(st.enable))
    else $error("access without byte lanes changed mask");

  chk_no_lane_rdata: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
    (reg_sel && cmd_byte_sel_n == 4'hf) |=> reg_rdata == 32'h0000_0000)
    else $error("access without byte lanes returned data");

endmodule

// File: verif/host_model.sv
// Host side model: word reads and writes on the register port
module host_model (
  // Clock and returned data
  input  wire logic        ref_clk,
  input  wire logic [31:0] reg_rdata,
  // Request
  output logic             reg_sel,
  output logic             reg_write,
  output logic [11:0]      reg_addr,
  output logic [3:0]       cmd_byte_sel_n,
  output logic [31:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_sel = 1'b0;
    reg_write = 1'b0;
    reg_addr = 12'h000;
    cmd_byte_sel_n = 4'hf;
    reg_wdata = 32'h0;
  end
  // One access per call; select stands for exactly one edge
  task automatic access(input logic wr, input logic [11:0] ad, input logic [3:0] ln,
                        input logic [31:0] d, output logic [31:0] q);
    @(negedge ref_clk);
    reg_sel <= 1'b1;
    reg_write <= wr;
    reg_addr <= ad;
    cmd_byte_sel_n <= ln;
    reg_wdata <= d;
    @(negedge ref_clk);
    reg_sel <= 1'b0;
    // Idle bus carries junk, not the old value
    reg_addr <= ~ad;
    reg_wdata <= ~d;
    q = reg_rdata;
  endtask
endmodule

// File: verif/tb_top.sv
// Random and corner-case bench for the event aggregator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] EN = irq_agg_pkg::ENABLE_OFFSET;
  localparam logic [11:0] ST = irq_agg_pkg::STATUS_OFFSET;
  // Sources whose strobe needs a qualifier, plus the frame report
  localparam logic [15:0] QUAL = 16'he630;
  logic        ref_clk;
  logic        reset_n;
  logic [15:0] a;
  logic [15:0] b;
  logic [1:0]  k;
  logic [15:0] fb;
  logic [15:0] mb;
  logic        c32;
  logic [31:0] reg_rdata;
  logic [31:0] reg_wdata;
  logic [31:0] q;
  logic [11:0] reg_addr;
  logic [3:0]  cmd_byte_sel_n;
  logic        reg_sel;
  logic        reg_write;
  logic        host_irq_n;
  logic [15:0] en;
  logic        full;
  logic        hit;
  int          i;
  int          fail_count;
  int          n_checks;
  wire rx_frame_end = a[2] | a[4], rx_crc_mismatch = a[2], rx_ones_run_hit = a[3];
  wire [15:0] rx_frame_bits = fb, rx_max_bits = mb;
  wire rx_crc32_mode = c32, rx_fifo_write = a[5], rx_fifo_full = b[5];
  wire rx_small_batch_done = a[6], rx_large_batch_done = a[7], rx_ready_batch_done = a[8];
  wire rx_free_request = a[9], rx_small_empty = b[9], rx_large_empty = b[9] | k[0];
  wire rx_ready_write = a[10], rx_ready_full = b[10], tx_free_batch_done = a[11];
  wire tx_ready_batch_done = a[12], tx_free_write = a[13], tx_free_full = b[13];
  wire tx_packet_done = a[14], notify_on_done = b[14], tx_fifo_read = a[15];
  wire tx_fifo_empty = b[15], addr_parity_err = a[0] && k == 2'h0;
  wire special_data_parity_err = a[0] && k == 2'h1, master_abort_seen = a[0] && k == 2'h2;
  wire target_abort_seen = a[0] && k == 2'h3, master_data_parity_err = a[1] && !k[0];
  wire parity_fault_in_n = !(a[1] && k[0]);
  master_interrupt_aggregator uut (.*);
  host_model host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic fmt_bad(input logic [15:0] n, input logic [15:0] mx, input logic m);
    return n > mx || n < (m ? 16'h0030 : 16'h0020) || n[2:0] != 3'h0;
  endfunction
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic check_pin(input logic got, input logic exp, input string s);
    check_word({31'h0, got}, {31'h0, exp}, s);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // With f low a qualified source sees its strobe alone and must set nothing, except the frame report, which is still format-checked
  task automatic fire(input int j, input logic f, output logic h);
    @(negedge ref_clk);
    k = 2'($urandom);
    fb = (j == 2) ? 16'h0040 : 16'($urandom_range(80));
    mb = (j == 2) ? 16'h0400 : 16'($urandom_range(72, 40));
    c32 = 1'($urandom);
    a[j] = f || QUAL[j];
    b[j] = f;
    h = (j == 4) ? fmt_bad(fb, mb, c32) : f;
    @(negedge ref_clk);
    a = 16'h0;
    b = 16'h0;
  endtask
  task automatic frame(input logic [15:0] n, input logic [15:0] mx, input logic m);
    @(negedge ref_clk);
    {fb, mb, c32, a} = {n, mx, m, 16'h0010};
    @(negedge ref_clk);
    a = 16'h0;
    host.access(1'b0, ST, 4'h0, 32'h0, q);
    check_word(q, {27'h0, fmt_bad(n, mx, m), 4'h0}, "frame corner");
  endtask
  initial begin
    #100us;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {a, b, k, fb, mb, c32} = '0;
    fail_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    void'($urandom(19289));
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check_pin(host_irq_n, 1'b1, "irq after reset");
    host.access(1'b0, EN, 4'h0, 32'h0, q);
    check_word(q, 32'h0, "enable reset");
    host.access(1'b0, ST, 4'h0, 32'h0, q);
    check_word(q, 32'h0, "status reset");
    $display("test reset done");
    for (int n = 0; n < 96; n++) begin
      i = $urandom_range(15);
      full = 1'($urandom);
      en = 16'($urandom);
      host.access(1'b1, EN, 4'($urandom_range(14)), {16'($urandom), en}, q);
      host.access(1'b0, EN, 4'($urandom_range(14)), 32'h0, q);
      check_word(q, {16'h0, en}, "enable readback");
      fire(i, full, hit);
      repeat (3) @(negedge ref_clk);
      check_pin(host_irq_n, !(hit && en[i]), "irq level");
      host.access(1'b0, ST, 4'($urandom_range(14)), 32'h0, q);
      check_word(q, {16'h0, {15'h0, hit} << i}, "status");
      @(negedge ref_clk);
      check_pin(host_irq_n, 1'b1, "irq after read");
      host.access(1'b0, ST, 4'h0, 32'h0, q);
      check_word(q, 32'h0, "status cleared");
    end
    $display("test random events done");
    frame(16'h0018, 16'h0400, 1'b0);
    frame(16'h0020, 16'h0020, 1'b0);
    frame(16'h0028, 16'h0400, 1'b1);
    frame(16'h0030, 16'h0030, 1'b1);
    frame(16'h0038, 16'h0030, 1'b1);
    frame(16'h0044, 16'h0400, 1'b0);
    $display("test frame corners done");
    fire(3, 1'b1, hit);
    host.access(1'b0, ST, 4'hf, 32'h0, q);
    check_word(q, 32'h0, "lanes off read");
    host.access(1'b1, EN, 4'hf, 32'h0, q);
    host.access(1'b0, 12'h00c, 4'h0, 32'h0, q);
    check_word(q, 32'h0, "unmapped read");
    host.access(1'b1, 12'h00c, 4'h0, 32'hffff_ffff, q);
    host.access(1'b0, EN, 4'h0, 32'h0, q);
    check_word(q, {16'h0, en}, "lanes off write");
    host.access(1'b0, ST, 4'h0, 32'h0, q);
    check_word(q, 32'h0008, "status kept");
    $display("test byte lanes done");
    summarize();
  end
endmodule
